/* rsch_defines.svh */
// Constants of the streaming read command handler: register selects,
// field positions, reset values and timing counts.
// Assumes a 20 MHz core clock and an 8-bit command block bus.
`ifndef RSCH_DEFINES_SVH
`define RSCH_DEFINES_SVH

// ============================================================
// Command block selects (reads share selects 1 and 7)
`define RSCH_SEL_DATA      3'h0
`define RSCH_SEL_FEATURE   3'h1
`define RSCH_SEL_COUNT     3'h2
`define RSCH_SEL_LBA_LO    3'h3
`define RSCH_SEL_LBA_MID   3'h4
`define RSCH_SEL_LBA_HI    3'h5
`define RSCH_SEL_DEVICE    3'h6
`define RSCH_SEL_COMMAND   3'h7

// ============================================================
// Command code and device register fixed bits
`define RSCH_CMD_READ_STREAM 8'h2B
`define RSCH_DEV_FIXED       3'h7
`define RSCH_DEV_FIXED_LSB   5

// ============================================================
// Current feature byte fields
`define RSCH_FEAT_URGENT     7
`define RSCH_FEAT_CONTINUOUS 6
`define RSCH_FEAT_NONSEQ     5
`define RSCH_FEAT_RESUME     4
`define RSCH_FEAT_SID_MSB    2

// ============================================================
// Status and error register bits, reset values
`define RSCH_ST_BUSY   7
`define RSCH_ST_READY  6
`define RSCH_ST_SERR   5
`define RSCH_ST_ERR    0
`define RSCH_ER_CRC    7
`define RSCH_ER_UNC    6
`define RSCH_ER_ID_NOT_FOUND_ERROR   4
`define RSCH_ER_COMMAND_ABORTED_ERROR   2
`define RSCH_ER_COMPLETION_TIMEOUT_FLAG   0
`define RSCH_STATUS_RESET 8'h40
`define RSCH_ERROR_RESET  8'h00

// ============================================================
// Sector counts and timing
`define RSCH_MAX_SECTORS    17'h10000
`define RSCH_CLK_PERIOD_NS  50
`define RSCH_NS_PER_US      1000
`define RSCH_CYC_PER_US     ((`RSCH_NS_PER_US + `RSCH_CLK_PERIOD_NS - 1) / `RSCH_CLK_PERIOD_NS)
`define RSCH_MIN_LIMIT_US   40'h0000000064

`endif

/* rsch_pkg.sv */
// Types of the streaming read command handler.
// Assumes rsch_defines.svh supplies the numeric constants.
package rsch_pkg;
  // ============================================================
  // Command sequencer states
  typedef enum logic [1:0] {
    RSCH_IDLE,
    RSCH_ISSUE,
    RSCH_WAIT,
    RSCH_FINISH
  } rsch_state_e;

  // Media error report of one sector
  typedef struct packed {
    logic crc;
    logic uncorrectable_error;
    logic id_not_found_error;
    logic command_aborted_error;
  } rsch_mederr_s;
endpackage

/* rsch_timer_if.sv */
// Carrier between the command sequencer and its time limit counter.
// Assumes both ends run on the same clock.
interface rsch_timer_if;
  logic        start;
  logic        stop;
  logic        enable;
  logic [39:0] limitUs;
  logic        expired;

  modport ctrl  (output start, output stop, output enable, output limitUs, input expired);
  modport timer (input start, input stop, input enable, input limitUs, output expired);
endinterface

/* rsch_limit_timer.sv */
// Completion time limit counter: microsecond prescaler and countdown.
// Assumes start and stop are single-cycle pulses from the sequencer.
`include "rsch_defines.svh"

module rsch_limit_timer #(
  parameter int CYC_PER_US = `RSCH_CYC_PER_US
) (
  input wire logic   clk,
  input wire logic   arst_n,
  rsch_timer_if.timer tmr
);
  localparam int PW = $clog2(CYC_PER_US + 1);

  logic          running_ff;
  logic [PW-1:0] presc_ff;
  logic [39:0]   remUs_ff;
  logic          expired_ff;
  wire           usTick = running_ff && (presc_ff == PW'(CYC_PER_US - 1));
  wire           lastUs = usTick && (remUs_ff == 40'h0000000001);

  assign tmr.expired = expired_ff;

  // ============================================================
  // Countdown; a zero-length or disabled limit never expires
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      running_ff <= 1'b0;
      presc_ff   <= '0;
      remUs_ff   <= 40'h0000000000;
      expired_ff <= 1'b0;
    end else if (tmr.start) begin
      running_ff <= tmr.enable && (tmr.limitUs != 40'h0000000000);
      presc_ff   <= '0;
      remUs_ff   <= tmr.limitUs;
      expired_ff <= 1'b0;
    end else if (tmr.stop || lastUs) begin
      running_ff <= 1'b0;
      expired_ff <= lastUs; // Measured up to the completion interrupt
    end else if (running_ff) begin
      presc_ff <= usTick ? '0 : presc_ff + PW'(1);
      remUs_ff <= usTick ? remUs_ff - 40'h0000000001 : remUs_ff;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_expire_needs_run;
    $rose(expired_ff) |-> $past(running_ff) && !running_ff;
  endproperty
  a_expire_needs_run: assert property (p_expire_needs_run) else $error("limit expired while idle");
endmodule

/* rsch_read_stream_handler.sv */
// Streaming read command handler: command block, sector sequencing,
// time limit, ending status and error log.
// Assumes the host bus and media engine are logic on the same clock.
`include "rsch_defines.svh"

// Operation
// - Urgent flag forwarded; command always ends when the time limit expires.
// - Continuous read never aborts on read or transfer errors.
// - Continuous read with errors: full transfer, stream error, no error summary, log.
// - Continuous read and limit expired: halt, stream error, timeout logged.
// - In continuous mode every requested sector is attempted while the limit allows.
// - Resume flag tells media to continue recovery at last error address.
// - Stream identifier is feature bits 2:0 and steers the command.
// - Limit in microseconds is previous feature times identify time unit.
// - Zero previous feature uses stream default; zero default means no limit.
// - Limit measured from command write to completion interrupt.
// - Limits below the device minimum are raised to the minimum.
// - Sector count is previous byte high, current byte low.
// - Sector count zero means 65536 sectors.
// - Block address assembled from six current and previous bytes.
// - Stream error returns the first faulty sector address in address bytes.
// - Stream error returns the consecutive faulty sector run in the count.
// - Timeout sets error register bit 0.
// - Continuous read error sets status bit 5, clears summary, logs bits.
// - Continuous flag clear selects normal streaming mode.
// - Command 2Bh accepted only with device bits 7:5 all ones.
module rsch_read_stream_handler #(
  parameter logic [39:0] MIN_LIMIT_US = `RSCH_MIN_LIMIT_US,
  parameter int          CYC_PER_US   = `RSCH_CYC_PER_US
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        regWr,
  input  wire logic [2:0]  regSel,
  input  wire logic [7:0]  regWrData,
  input  wire logic        hobSel,
  output logic      [7:0]  regRdData,
  input  wire logic [31:0] identTimeUnit,
  input  wire logic [63:0] streamDefLimit,
  output logic             secReq,
  output logic      [47:0] secLba,
  output logic      [2:0]  streamId,
  output logic             urgentMode,
  output logic             nonSeqHint,
  output logic             resumeRecovery,
  output logic             mediaHalt,
  input  wire logic        secDone,
  input  wire logic [3:0]  secErr,
  output logic             logWrite,
  output logic      [7:0]  logBits,
  output logic      [2:0]  logStream,
  output logic             intrq
);
  rsch_pkg::rsch_state_e state_ff, nxt_state;
  logic [7:0]  tfCur_ff [5];
  logic [7:0]  tfPrev_ff [5];
  logic [7:0]  device_ff, status_ff, error_ff, feat_ff;
  logic [47:0] lba_ff, firstErrLba_ff;
  logic [16:0] remain_ff;
  logic [15:0] errRun_ff;
  logic [7:0]  errAcc_ff;
  logic        anyErr_ff, runOpen_ff, timedOut_ff, intrq_ff, logWrite_ff, halt_ff;
  logic [7:0]  logBits_ff;
  rsch_timer_if tmrIf ();

  // ============================================================
  // Decode of host writes and the command
  wire       busy      = status_ff[`RSCH_ST_BUSY];
  wire       wrCmd     = regWr && !busy && (regSel == `RSCH_SEL_COMMAND);
  wire       cmdLegal  = (regWrData == `RSCH_CMD_READ_STREAM)
                         && (device_ff[7:`RSCH_DEV_FIXED_LSB] == `RSCH_DEV_FIXED);
  wire       cmdGo     = wrCmd && cmdLegal;
  wire       cmdReject = wrCmd && !cmdLegal;
  wire       wrTf      = regWr && !busy && (regSel >= `RSCH_SEL_FEATURE) && (regSel <= `RSCH_SEL_LBA_HI);
  wire [2:0] tfIdx     = regSel - `RSCH_SEL_FEATURE;
  wire [2:0] newSid    = tfCur_ff[0][`RSCH_FEAT_SID_MSB:0];
  wire       contMode  = feat_ff[`RSCH_FEAT_CONTINUOUS]; // Clear means normal mode

  // Count and address assembly; zero count stands for the maximum
  wire [15:0] cntRaw   = {tfPrev_ff[1], tfCur_ff[1]};
  wire [16:0] cntEff   = (cntRaw == 16'h0000) ? `RSCH_MAX_SECTORS : {1'b0, cntRaw};
  wire [47:0] lbaIn    = {tfPrev_ff[4], tfPrev_ff[3], tfPrev_ff[2],
                          tfCur_ff[4], tfCur_ff[3], tfCur_ff[2]};

  // Time limit: explicit multiplier, else stream default, then raised to the minimum
  wire [7:0]  defLimit = streamDefLimit[newSid*8 +: 8];
  wire [7:0]  limMult  = (tfPrev_ff[0] != 8'h00) ? tfPrev_ff[0] : defLimit;
  wire [39:0] limRaw   = 40'(limMult) * 40'(identTimeUnit);
  wire [39:0] limUs    = (limRaw < MIN_LIMIT_US) ? MIN_LIMIT_US : limRaw;

  assign tmrIf.start   = cmdGo; // Measured from the command write
  assign tmrIf.stop    = (state_ff == rsch_pkg::RSCH_FINISH);
  assign tmrIf.enable  = (limMult != 8'h00) && (identTimeUnit != 32'h00000000);
  assign tmrIf.limitUs = limUs;

  // Sector result decode into error register positions
  rsch_pkg::rsch_mederr_s medErr;
  assign medErr = rsch_pkg::rsch_mederr_s'(secErr);
  wire        sectorBad = secDone && (secErr != 4'h0);
  wire [7:0]  sectorBits = {medErr.crc, medErr.uncorrectable_error, 1'b0, medErr.id_not_found_error, 1'b0, medErr.command_aborted_error, 2'b00};
  wire        expiredNow = tmrIf.expired && busy && (state_ff != rsch_pkg::RSCH_FINISH);
  wire [7:0]  cctoBit    = {7'h00, timedOut_ff};

  rsch_limit_timer #(
    .CYC_PER_US(CYC_PER_US)
  ) u_timer (
    .clk   (clk),
    .arst_n(arst_n),
    .tmr   (tmrIf)
  );

  // ============================================================
  // Sequencer: one sector request at a time until count, normal-mode error or timeout
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rsch_pkg::RSCH_IDLE:   nxt_state = cmdGo ? rsch_pkg::RSCH_ISSUE : rsch_pkg::RSCH_IDLE;
      rsch_pkg::RSCH_ISSUE:  nxt_state = expiredNow ? rsch_pkg::RSCH_FINISH : rsch_pkg::RSCH_WAIT;
      rsch_pkg::RSCH_WAIT: begin
        if (expiredNow) begin
          nxt_state = rsch_pkg::RSCH_FINISH; // Halt on expiry
        end else if (secDone) begin
          if (sectorBad && !contMode) begin
            nxt_state = rsch_pkg::RSCH_FINISH;
          end else if (remain_ff == 17'h00001) begin
            nxt_state = rsch_pkg::RSCH_FINISH;
          end else begin
            nxt_state = rsch_pkg::RSCH_ISSUE; // Errors do not stop continuous read
          end
        end
      end
      rsch_pkg::RSCH_FINISH: nxt_state = rsch_pkg::RSCH_IDLE;
      default:               nxt_state = rsch_pkg::RSCH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_ff <= rsch_pkg::RSCH_IDLE;
    else         state_ff <= nxt_state;
  end

  // ============================================================
  // Transfer progress and faulty run tracking
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      feat_ff        <= 8'h00;
      lba_ff         <= 48'h000000000000;
      remain_ff      <= 17'h00000;
      firstErrLba_ff <= 48'h000000000000;
      errRun_ff      <= 16'h0000;
      errAcc_ff      <= 8'h00;
      anyErr_ff      <= 1'b0;
      runOpen_ff     <= 1'b0;
      timedOut_ff    <= 1'b0;
    end else if (cmdGo) begin
      feat_ff     <= tfCur_ff[0];
      lba_ff      <= lbaIn;
      remain_ff   <= cntEff;
      errRun_ff   <= 16'h0000;
      errAcc_ff   <= 8'h00;
      anyErr_ff   <= 1'b0;
      runOpen_ff  <= 1'b0;
      timedOut_ff <= 1'b0;
    end else begin
      if (expiredNow) timedOut_ff <= 1'b1;
      if (secDone && state_ff == rsch_pkg::RSCH_WAIT && !expiredNow) begin
        lba_ff    <= lba_ff + 48'h000000000001;
        remain_ff <= remain_ff - 17'h00001;
        errAcc_ff <= errAcc_ff | sectorBits;
        if (sectorBad && !anyErr_ff) begin
          firstErrLba_ff <= lba_ff;
          errRun_ff      <= 16'h0001;
          runOpen_ff     <= 1'b1;
        end else if (sectorBad && runOpen_ff) begin
          errRun_ff <= errRun_ff + 16'h0001; // Only an unbroken run counts
        end else if (!sectorBad) begin
          runOpen_ff <= 1'b0;
        end
        anyErr_ff <= anyErr_ff | sectorBad;
      end
    end
  end

  // ============================================================
  // Command block registers; writes while busy are ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 5; i++) begin
        tfCur_ff[i]  <= 8'h00;
        tfPrev_ff[i] <= 8'h00;
      end
      device_ff <= 8'h00;
    end else if (state_ff == rsch_pkg::RSCH_FINISH && anyErr_ff) begin
      {tfPrev_ff[4], tfPrev_ff[3], tfPrev_ff[2], tfCur_ff[4], tfCur_ff[3], tfCur_ff[2]} <= firstErrLba_ff;
      {tfPrev_ff[1], tfCur_ff[1]} <= errRun_ff;
    end else if (wrTf) begin
      tfPrev_ff[tfIdx] <= tfCur_ff[tfIdx];
      tfCur_ff[tfIdx]  <= regWrData;
    end else if (regWr && !busy && regSel == `RSCH_SEL_DEVICE) begin
      device_ff <= regWrData;
    end
  end

  // ============================================================
  // Ending status, error register, error log and interrupt
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff   <= `RSCH_STATUS_RESET;
      error_ff    <= `RSCH_ERROR_RESET;
      intrq_ff    <= 1'b0;
      logWrite_ff <= 1'b0;
      logBits_ff  <= 8'h00;
      halt_ff     <= 1'b0;
    end else begin
      intrq_ff    <= 1'b0;
      logWrite_ff <= 1'b0;
      halt_ff     <= expiredNow;
      if (cmdGo) begin
        status_ff <= 8'h80;
        error_ff  <= 8'h00;
      end else if (cmdReject) begin
        status_ff <= 8'h41;
        error_ff  <= 8'h04;
        intrq_ff  <= 1'b1;
      end else if (state_ff == rsch_pkg::RSCH_FINISH) begin
        intrq_ff <= 1'b1;
        if (contMode) begin
          status_ff   <= {2'b01, anyErr_ff | timedOut_ff, 5'h00};
          error_ff    <= cctoBit;
          logWrite_ff <= anyErr_ff | timedOut_ff;
          logBits_ff  <= errAcc_ff | cctoBit;
        end else begin
          status_ff <= {7'h20, anyErr_ff | timedOut_ff};
          error_ff  <= errAcc_ff | cctoBit;
        end
      end
    end
  end

  // ============================================================
  // Outputs to host and media
  wire [7:0] tfRead = hobSel ? tfPrev_ff[tfIdx] : tfCur_ff[tfIdx];
  assign regRdData = (regSel == `RSCH_SEL_COMMAND) ? status_ff :
                     (regSel == `RSCH_SEL_FEATURE) ? error_ff :
                     (regSel == `RSCH_SEL_DEVICE)  ? device_ff :
                     (regSel == `RSCH_SEL_DATA)    ? 8'h00 : tfRead;
  assign secReq         = (state_ff == rsch_pkg::RSCH_ISSUE) && !expiredNow;
  assign secLba         = lba_ff;
  assign streamId       = feat_ff[`RSCH_FEAT_SID_MSB:0];
  assign urgentMode     = feat_ff[`RSCH_FEAT_URGENT];
  assign nonSeqHint     = feat_ff[`RSCH_FEAT_NONSEQ];
  assign resumeRecovery = feat_ff[`RSCH_FEAT_RESUME];
  assign mediaHalt      = halt_ff;
  assign logWrite       = logWrite_ff;
  assign logBits        = logBits_ff;
  assign logStream      = streamId;
  assign intrq          = intrq_ff;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_accept;
    cmdGo |=> busy && state_ff == rsch_pkg::RSCH_ISSUE;
  endproperty
  a_accept: assert property (p_accept) else $error("legal command not accepted");

  property p_zero_count;
    cmdGo && cntRaw == 16'h0000 |=> remain_ff == `RSCH_MAX_SECTORS;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count not taken as maximum");

  property p_lba;
    cmdGo |=> secLba == $past(lbaIn) && secReq;
  endproperty
  a_lba: assert property (p_lba) else $error("first sector address wrong");

  property p_cont_no_summary;
    $rose(intrq) && contMode && !$past(cmdReject) |-> !status_ff[`RSCH_ST_ERR];
  endproperty
  a_cont_no_summary: assert property (p_cont_no_summary) else $error("summary set in continuous read");

  property p_cont_serr;
    state_ff == rsch_pkg::RSCH_FINISH && contMode && anyErr_ff |=> status_ff[`RSCH_ST_SERR] && logWrite;
  endproperty
  a_cont_serr: assert property (p_cont_serr) else $error("stream error not reported");

  property p_timeout;
    expiredNow |-> ##[1:2] intrq && error_ff[`RSCH_ER_COMPLETION_TIMEOUT_FLAG];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not ended with flag");

  property p_min_limit;
    cmdGo && tmrIf.enable |=> u_timer.running_ff && u_timer.remUs_ff >= MIN_LIMIT_US;
  endproperty
  a_min_limit: assert property (p_min_limit) else $error("limit below minimum");

  property p_normal_stop;
    state_ff == rsch_pkg::RSCH_WAIT && sectorBad && !contMode && !expiredNow
      |=> state_ff == rsch_pkg::RSCH_FINISH ##1 status_ff[`RSCH_ST_ERR];
  endproperty
  a_normal_stop: assert property (p_normal_stop) else $error("normal mode error not ending");

  property p_cont_keeps_going;
    state_ff == rsch_pkg::RSCH_WAIT && sectorBad && contMode && !expiredNow && remain_ff > 17'h00001
      |=> secReq;
  endproperty
  a_cont_keeps_going: assert property (p_cont_keeps_going) else $error("continuous read stopped");
endmodule

/* rsch_media_model.sv */
// Media engine stand-in: answers each sector request after a set delay.
// Assumes one outstanding sector at a time, on the handler's clock.
module rsch_media_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        secReq,
  input  wire logic [47:0] secLba,
  input  wire logic        mediaHalt,
  input  wire logic [7:0]  latency,
  input  wire logic [47:0] errLba,
  input  wire logic [7:0]  errRun,
  input  wire logic [3:0]  errBits,
  output logic             secDone,
  output logic      [3:0]  secErr
);
  // ============================================================
  // Sector timing
  logic [7:0]  wait_ff;
  logic        busy_ff;
  logic        done_ff;
  logic [47:0] lba_ff;
  wire logic   inRun = (lba_ff >= errLba) && (lba_ff < errLba + 48'(errRun));

  // Halt drops the outstanding sector so no stale answer follows it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      lba_ff  <= 48'h000000000000;
    end else begin
      done_ff <= busy_ff && (wait_ff == 8'h00) && !mediaHalt;
      if (mediaHalt || (busy_ff && wait_ff == 8'h00)) begin
        busy_ff <= 1'b0;
      end else if (secReq) begin
        busy_ff <= 1'b1;
        wait_ff <= latency;
        lba_ff  <= secLba;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 8'h01;
      end
    end
  end

  // Error code is only meaningful with the answer; garbage otherwise
  assign secDone = done_ff;
  assign secErr  = done_ff ? (inRun ? errBits : 4'h0) : 4'hA;
endmodule

/* read_stream_command_handler_test.sv */
// Self-checking bench of the streaming read command handler.
// Assumes rsch_defines.svh, the package, the handler and the media model.
`include "rsch_defines.svh"
module read_stream_command_handler_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Prescaler shortened so a 100 us minimum limit is 200 cycles
  localparam int CPU    = 2;
  localparam int MINCYC = int'(`RSCH_MIN_LIMIT_US) * CPU;
  logic        clk, arst_n, regWr, hobSel, secReq, secDone, mediaHalt;
  logic        urgentMode, nonSeqHint, resumeRecovery, logWrite, intrq;
  logic [2:0]  regSel, streamId, logStream;
  logic [7:0]  regWrData, regRdData, logBits, latency, errRun, logSeen;
  logic [31:0] identTimeUnit;
  logic [63:0] streamDefLimit;
  logic [47:0] secLba, errLba, expLba;
  logic [3:0]  secErr, errBits;
  int          cyc, cmdCyc, intCyc, reqCnt, intrqCnt, haltCnt, error_cnt, check_count;

  rsch_read_stream_handler #(.CYC_PER_US(CPU)) i_rsch_read_stream_handler (
    .clk(clk), .arst_n(arst_n), .regWr(regWr), .regSel(regSel), .regWrData(regWrData),
    .hobSel(hobSel), .regRdData(regRdData), .identTimeUnit(identTimeUnit),
    .streamDefLimit(streamDefLimit), .secReq(secReq), .secLba(secLba), .streamId(streamId),
    .urgentMode(urgentMode), .nonSeqHint(nonSeqHint), .resumeRecovery(resumeRecovery),
    .mediaHalt(mediaHalt), .secDone(secDone), .secErr(secErr), .logWrite(logWrite),
    .logBits(logBits), .logStream(logStream), .intrq(intrq));
  rsch_media_model i_rsch_media_model (
    .clk(clk), .arst_n(arst_n), .secReq(secReq), .secLba(secLba), .mediaHalt(mediaHalt),
    .latency(latency), .errLba(errLba), .errRun(errRun), .errBits(errBits),
    .secDone(secDone), .secErr(secErr));

  // ============================================================
  // Clock, comparison and closing
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Monitor: sector order, pulses, and a hang ceiling near five times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (secReq) begin
      chk(secLba, expLba + 48'(reqCnt));
      reqCnt <= reqCnt + 1;
    end
    if (intrq) begin
      intCyc   <= cyc;
      intrqCnt <= intrqCnt + 1;
    end
    if (mediaHalt) haltCnt <= haltCnt + 1;
    if (logWrite) logSeen <= logBits;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ============================================================
  // Host side of the command block
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk);
    regWr     = 1'b1;
    regSel    = sel;
    regWrData = d;
    @(negedge clk);
    regWr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] sel, input logic high_order_select, output logic [7:0] v);
    @(negedge clk);
    regSel = sel;
    hobSel = high_order_select;
    #1 v = regRdData;
  endtask

  // Previous bytes first, then current; waits for the completion pulse
  task automatic issue(input logic [7:0] fp, input logic [7:0] fc, input logic [15:0] cnt,
                       input logic [47:0] lba, input logic [7:0] dev, input logic [7:0] cmd);
    expLba   = lba;
    reqCnt   = 0;
    intrqCnt = 0;
    haltCnt  = 0;
    logSeen  = 8'h00;
    wr(3'h1, fp);
    wr(3'h1, fc);
    wr(3'h2, cnt[15:8]);
    wr(3'h2, cnt[7:0]);
    for (int s = 0; s < 6; s++) wr(3'(3 + s % 3), lba[(s < 3 ? 24 : 0) + (s % 3) * 8 +: 8]);
    wr(3'h6, dev);
    wr(3'h7, cmd);
    cmdCyc = cyc - 1;
    for (int i = 0; i < 5000 && intrqCnt == 0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask

  task automatic ending(input logic [7:0] st, input logic [7:0] er);
    logic [7:0] v;
    chk(64'(intrqCnt), 64'h1);
    rd(3'h7, 1'b0, v);
    chk(v, st);
    rd(3'h1, 1'b0, v);
    chk(v, er);
  endtask

  task automatic faultRegs(input logic [47:0] a, input logic [15:0] n);
    logic [7:0] v;
    for (int h = 0; h < 2; h++) begin
      for (int s = 0; s < 3; s++) begin
        rd(3'(3 + s), h[0], v);
        chk(v, a[h * 24 + s * 8 +: 8]);
      end
      rd(3'h2, h[0], v);
      chk(v, n[h * 8 +: 8]);
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic test_normal();
    latency        = 8'h02;
    errRun         = 8'h00;
    streamDefLimit = 64'h0;
    issue(8'h00, 8'hF5, 16'h0102, 48'hA1B2C3D4E5F6, 8'hF0, `RSCH_CMD_READ_STREAM);
    chk(64'(reqCnt), 64'd258);
    chk(streamId, 3'h5);
    chk(urgentMode, 1'b1);
    chk(nonSeqHint, 1'b1);
    chk(resumeRecovery, 1'b1);
    ending(8'h40, 8'h00);
    $display("test normal done");
  endtask

  // Each media error code in turn, continuous mode never stops early
  task automatic test_continuous();
    logic [7:0] logExp [4] = '{8'h80, 8'h40, 8'h10, 8'h04};
    for (int k = 0; k < 4; k++) begin
      latency = 8'h00;
      errBits = 4'b1000 >> k;
      errLba  = 48'h000012345679;
      errRun  = 8'h02;
      issue(8'h00, 8'h42, 16'h0006, 48'h000012345678, 8'hE0, `RSCH_CMD_READ_STREAM);
      chk(64'(reqCnt), 64'd6);
      chk(64'(haltCnt), 64'h0);
      ending(8'h60, 8'h00);
      chk(logSeen, logExp[k]);
      chk(logStream, 3'h2);
      faultRegs(48'h000012345679, 16'h0002);
    end
    $display("test continuous done");
  endtask

  task automatic test_normal_error();
    errBits = 4'b0010;
    errLba  = 48'h00000000AA02;
    errRun  = 8'h01;
    issue(8'h00, 8'h01, 16'h0005, 48'h00000000AA00, 8'hE0, `RSCH_CMD_READ_STREAM);
    chk(64'(reqCnt), 64'd3);
    chk({streamId, urgentMode, nonSeqHint, resumeRecovery}, 6'h08);
    ending(8'h41, 8'h10);
    faultRegs(48'h00000000AA02, 16'h0001);
    $display("test normal error done");
  endtask

  // Stream default of 1 us is raised to the minimum limit
  task automatic test_timeout();
    latency        = 8'h0A;
    errRun         = 8'h00;
    identTimeUnit  = 32'h00000001;
    streamDefLimit = 64'h0000000001000000;
    issue(8'h00, 8'h43, 16'h0032, 48'h000000001000, 8'hE0, `RSCH_CMD_READ_STREAM);
    chk(64'(haltCnt), 64'h1);
    chk(64'(reqCnt < 50), 64'h1);
    chk(64'(intCyc - cmdCyc >= MINCYC - 1 && intCyc - cmdCyc <= MINCYC + 8), 64'h1);
    ending(8'h60, 8'h01);
    chk(logSeen, 8'h01);
    $display("test timeout done");
  endtask

  // Count zero must outlast 256 sectors; limit is 255 times 4 us
  task automatic test_count_zero();
    latency        = 8'h00;
    identTimeUnit  = 32'h00000004;
    streamDefLimit = 64'h0;
    issue(8'hFF, 8'h00, 16'h0000, 48'h000000002000, 8'hF0, `RSCH_CMD_READ_STREAM);
    chk(64'(reqCnt > 256), 64'h1);
    chk(64'(intCyc - cmdCyc >= 2040 - 1 && intCyc - cmdCyc <= 2040 + 8), 64'h1);
    ending(8'h41, 8'h01);
    $display("test count zero done");
  endtask

  task automatic test_illegal();
    logic [7:0] dev [2] = '{8'h40, 8'hE0};
    logic [7:0] cmd [2] = '{8'h2B, 8'h2A};
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      issue(8'h00, 8'h00, 16'h0001, 48'h0, dev[k], cmd[k]);
      chk(64'(reqCnt), 64'h0);
      ending(8'h41, 8'h04);
      rd(3'h6, 1'b0, v);
      chk(v, dev[k]);
    end
    $display("test illegal done");
  endtask

  // ============================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    {arst_n, regWr, hobSel, regSel, regWrData} = '0;
    {latency, errRun, errBits, errLba, expLba} = '0;
    identTimeUnit  = 32'h00000001;
    streamDefLimit = 64'h0;
    {cyc, reqCnt, intrqCnt, haltCnt, error_cnt, check_count} = '0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    rd(3'h7, 1'b0, v);
    chk(v, `RSCH_STATUS_RESET);
    rd(3'h1, 1'b0, v);
    chk(v, `RSCH_ERROR_RESET);
    $display("test reset done");
    test_normal();
    test_continuous();
    test_normal_error();
    test_timeout();
    test_count_zero();
    test_illegal();
    complete_run();
  end
endmodule
